// [design/crt_raster_timing.sv]
`timescale 1ns/10ps
module crt_raster_timing import crt_pkg::*; (
  // Character clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins from the board
  input wire logic display_reset_n,
  input wire logic format_select,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Video timing
  output logic [13:0] refresh_addr,
  output logic [4:0] char_row_addr,
  output logic [18:0] graphics_addr,
  output logic hsync_out,
  output logic vsync_out,
  output logic display_active,
  output logic cursor_out
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  crt_cfg_if cfg ();

  crt_axil_regs u_regs (
    .mclk(mclk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .cfg(cfg.regs)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic run_meta_q;  // First stage, read only by second
  logic run_q;       // Display may run
  logic sel_meta_q;
  logic sel_q;       // Synchronised format choice

  // Two flops per pin; display held stopped while in reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_meta_q <= 1'b0;
      run_q <= 1'b0;
      sel_meta_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      run_meta_q <= display_reset_n;
      run_q <= run_meta_q;
      sel_meta_q <= format_select;
      sel_q <= sel_meta_q;
    end
  end

  // ----------------------------------------
  // Active format
  // ----------------------------------------
  crt_fmt_t fmt;        // Set chosen by the pin
  logic [7:0] h_half;   // Mid-line point for odd field

  // Low picks set zero, high picks set one
  assign fmt = sel_q ? CRT_FMT1 : CRT_FMT0;
  assign h_half = {1'b0, fmt.h_total[7:1]};

  // ----------------------------------------
  // Raster counters
  // ----------------------------------------
  logic [7:0] hcnt_q;   // Character within line
  logic [4:0] scan_q;   // Scan line within row
  logic [6:0] row_q;    // Character row within field
  logic field_q;        // High in odd field
  logic line_end;
  logic row_end;
  logic frame_end;

  // Greater-or-equal compares keep a format switch from
  // leaving a counter past its new total
  assign line_end = hcnt_q >= fmt.h_total;
  assign row_end = line_end && (scan_q >= fmt.max_scan);
  assign frame_end = row_end && (row_q >= fmt.v_total);

  // Character counter
  always_ff @(posedge mclk) begin
    if (rst || !run_q) begin
      hcnt_q <= 8'h00;
    end else if (line_end) begin
      hcnt_q <= 8'h00;
    end else begin
      hcnt_q <= hcnt_q + 8'h01;
    end
  end

  // Scan line counter, runs through retrace too
  always_ff @(posedge mclk) begin
    if (rst || !run_q) begin
      scan_q <= 5'h00;
    end else if (row_end) begin
      scan_q <= 5'h00;
    end else if (line_end) begin
      scan_q <= scan_q + 5'h01;
    end
  end

  // Row counter and field flag
  always_ff @(posedge mclk) begin
    if (rst || !run_q) begin
      row_q <= 7'h00;
      field_q <= 1'b0;
    end else if (frame_end) begin
      row_q <= 7'h00;
      // Toggle only when scanning interlaced
      field_q <= fmt.interlace && !field_q;
    end else if (row_end) begin
      row_q <= row_q + 7'h01;
    end
  end

  // ----------------------------------------
  // Refresh address generation
  // ----------------------------------------
  logic [13:0] ma_q;         // Current refresh address
  logic [13:0] line_base_q;  // Address of the row's first character

  // Counts every character, including retrace, so that dynamic
  // memory behind the address keeps being refreshed
  always_ff @(posedge mclk) begin
    if (rst) begin
      ma_q <= CRT_START_RST;
      line_base_q <= CRT_START_RST;
    end else if (!run_q || frame_end) begin
      ma_q <= cfg.start_addr;
      line_base_q <= cfg.start_addr;
    end else if (row_end) begin
      ma_q <= line_base_q + {6'h00, fmt.h_disp};
      line_base_q <= line_base_q + {6'h00, fmt.h_disp};
    end else if (line_end) begin
      ma_q <= line_base_q;
    end else begin
      ma_q <= ma_q + 14'h0001;
    end
  end

  // ----------------------------------------
  // Vertical sync
  // ----------------------------------------
  logic [3:0] vs_cnt_q;  // Scan lines of sync left
  logic vs_point;        // Line point where sync may change

  // The odd field moves its sync by half a line, which puts
  // its first line at the top centre
  assign vs_point = hcnt_q == (field_q ? h_half : 8'h00);

  // Sync length counter
  always_ff @(posedge mclk) begin
    if (rst || !run_q) begin
      vs_cnt_q <= 4'h0;
    end else if (vs_point && row_q == fmt.vs_pos && scan_q == 5'h00) begin
      vs_cnt_q <= fmt.vs_width;
    end else if (vs_point && vs_cnt_q != 4'h0) begin
      vs_cnt_q <= vs_cnt_q - 4'h1;
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  logic [8:0] hs_end;       // Sync end, one bit wider
  logic hsync_d;
  logic de_d;
  logic cursor_d;
  logic [13:0] refresh_q;
  logic [4:0] row_addr_q;
  logic hsync_q;
  logic vsync_q;
  logic de_q;
  logic cursor_q;

  assign hs_end = {1'b0, fmt.hs_pos} + {5'h00, fmt.hs_width};
  assign hsync_d = (hcnt_q >= fmt.hs_pos) && ({1'b0, hcnt_q} < hs_end);
  assign de_d = (hcnt_q < fmt.h_disp) && (row_q < fmt.v_disp);
  assign cursor_d = ma_q == cfg.cursor_addr;

  // All outputs flopped one stage behind the counters
  always_ff @(posedge mclk) begin
    if (rst) begin
      refresh_q <= CRT_START_RST;
      row_addr_q <= 5'h00;
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
      de_q <= 1'b0;
      cursor_q <= 1'b0;
    end else if (!run_q) begin
      // Stopped: address shows the scroll base, rest low
      refresh_q <= cfg.start_addr;
      row_addr_q <= 5'h00;
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
      de_q <= 1'b0;
      cursor_q <= 1'b0;
    end else begin
      refresh_q <= ma_q;
      row_addr_q <= scan_q;
      hsync_q <= hsync_d;
      vsync_q <= vs_cnt_q != 4'h0;
      de_q <= de_d;
      cursor_q <= cursor_d;
    end
  end

  assign refresh_addr = refresh_q;
  assign char_row_addr = row_addr_q;
  // Row above refresh gives the wide graphics address
  assign graphics_addr = {row_addr_q, refresh_q};
  assign hsync_out = hsync_q;
  assign vsync_out = vsync_q;
  assign display_active = de_q;
  assign cursor_out = cursor_q;

  // Live state for the status register
  assign cfg.st_addr = refresh_q;
  assign cfg.st_row = row_addr_q;
  assign cfg.st_field = field_q;
  assign cfg.st_hsync = hsync_q;
  assign cfg.st_vsync = vsync_q;
  assign cfg.st_de = de_q;
  assign cfg.st_run = run_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_stopped;
    !run_q [*2];
  endsequence

  sequence s_vs_rise;
    !vsync_out ##1 vsync_out;
  endsequence

  a_line_wrap: assert property (run_q && hcnt_q == fmt.h_total && $stable(sel_q)
    |=> hcnt_q == 8'h00)
    else $error("line counter did not wrap");

  a_scan_wrap: assert property (run_q && row_end && $stable(sel_q)
    |=> scan_q == 5'h00)
    else $error("scan counter did not wrap");

  a_addr_advance: assert property (run_q && $past(run_q) && !line_end
    |=> ma_q == $past(ma_q) + 14'h0001)
    else $error("refresh address stalled");

  a_frame_start: assert property (run_q && frame_end
    |=> ma_q == $past(cfg.start_addr))
    else $error("frame did not start at base");

  a_cursor_match: assert property (run_q ##1 cursor_out
    |-> $past(ma_q) == $past(cfg.cursor_addr))
    else $error("cursor without address match");

  a_reset_state: assert property (s_stopped |-> refresh_addr == $past(cfg.start_addr)
    && !hsync_out && !vsync_out && !display_active && !cursor_out
    && char_row_addr == 5'h00)
    else $error("stopped outputs wrong");

  a_de_window: assert property (display_active
    |-> $past(hcnt_q) < $past(fmt.h_disp))
    else $error("display enable outside window");

  a_field_sync: assert property (run_q [*3] ##0 s_vs_rise
    |-> $past(hcnt_q, 2) == (field_q ? h_half : 8'h00))
    else $error("vertical sync at wrong line point");

  a_graph_addr: assert property (##1 graphics_addr[18:14] == char_row_addr
    && graphics_addr[13:0] == ($past(run_q) ? $past(ma_q)
    : $past(cfg.start_addr)))
    else $error("graphics address mismatch");

endmodule : crt_raster_timing

// [design/crt_pkg.sv]
// Summary of operation
// - Two fixed formats drive all timing
// - Refresh address is fourteen bits wide
// - Row address is five bits wide
// - Row plus refresh form one graphics address
// - Addresses keep advancing during retrace
// - Cursor output when cursor equals refresh address
// - Each frame starts at start address
// - Interlace choice fixed within each format
// - Odd field vsync starts mid line
// - All timing from the one character clock
// - Outputs addresses, syncs and display enable
// - Display reset clears counters, shows start address
// - Index register and data register select
// - Write data taken on strobe completion
// - Format select low picks set zero
package crt_pkg;

  // ----------------------------------------
  // Screen format sets
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] h_total;  // Characters per line minus one
    logic [7:0] h_disp;   // Displayed characters per line
    logic [7:0] hs_pos;   // Horizontal sync start
    logic [3:0] hs_width; // Horizontal sync width
    logic [6:0] v_total;  // Character rows per field minus one
    logic [6:0] v_disp;   // Displayed character rows
    logic [6:0] vs_pos;   // Vertical sync row
    logic [3:0] vs_width; // Vertical sync width in scan lines
    logic [4:0] max_scan; // Scan lines per row minus one
    logic interlace;      // Interlaced scanning
  } crt_fmt_t;

  // Set zero: non-interlaced
  localparam crt_fmt_t CRT_FMT0 = '{8'h63, 8'h50, 8'h52, 4'hA,
    7'h19, 7'h18, 7'h18, 4'h3, 5'h09, 1'h0};
  // Set one: interlaced
  localparam crt_fmt_t CRT_FMT1 = '{8'h3F, 8'h28, 8'h30, 4'h6,
    7'h1F, 7'h18, 7'h1B, 4'h3, 5'h07, 1'h1};

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CRT_OFF_INDEX = 8'h00;
  localparam logic [7:0] CRT_OFF_DATA = 8'h04;
  localparam logic [7:0] CRT_OFF_STAT = 8'h08;
  localparam logic [4:0] CRT_IDX_START_HI = 5'h0C;
  localparam logic [4:0] CRT_IDX_START_LO = 5'h0D;
  localparam logic [4:0] CRT_IDX_CURS_HI = 5'h0E;
  localparam logic [4:0] CRT_IDX_CURS_LO = 5'h0F;
  localparam logic [4:0] CRT_INDEX_RST = 5'h00;
  localparam logic [13:0] CRT_START_RST = 14'h0000;
  localparam logic [13:0] CRT_CURS_RST = 14'h0000;
  localparam logic [1:0] CRT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CRT_RESP_SLVERR = 2'h2;

endpackage : crt_pkg

// [design/crt_cfg_if.sv]
`timescale 1ns/10ps
// Settings and live state between register file and raster core
interface crt_cfg_if;
  logic [13:0] start_addr;  // Scroll base
  logic [13:0] cursor_addr; // Cursor position
  logic [13:0] st_addr;     // Live refresh address
  logic [4:0] st_row;       // Live row address
  logic st_field;           // Odd field flag
  logic st_hsync;
  logic st_vsync;
  logic st_de;
  logic st_run;             // Display running
  modport regs (output start_addr, cursor_addr,
    input st_addr, st_row, st_field, st_hsync, st_vsync, st_de, st_run);
  modport core (input start_addr, cursor_addr,
    output st_addr, st_row, st_field, st_hsync, st_vsync, st_de, st_run);
endinterface : crt_cfg_if

// [design/crt_axil_regs.sv]
`timescale 1ns/10ps
module crt_axil_regs import crt_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write address and data
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // Write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // Read
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Core side
  crt_cfg_if.regs cfg
);

  logic aw_have_q;        // Address held
  logic [7:0] aw_addr_q;
  logic w_have_q;         // Data held
  logic [7:0] w_byte_q;
  logic w_lane_q;         // Low byte lane enabled
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [4:0] index_q;    // Register index
  logic [13:0] start_q;
  logic [13:0] curs_q;
  logic do_write;
  logic addr_ok;

  // ----------------------------------------
  // Write channels, taken in either order
  // ----------------------------------------
  assign s_axil_awready = !aw_have_q && !bvalid_q;
  assign s_axil_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign addr_ok = (aw_addr_q == CRT_OFF_INDEX) || (aw_addr_q == CRT_OFF_DATA);

  // Capture address and data, drop both once answered
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axil_wdata[7:0];
        w_lane_q <= s_axil_wstrb[0];
      end
    end
  end

  // Response follows both halves
  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= CRT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_ok ? CRT_RESP_OKAY : CRT_RESP_SLVERR;
    end else if (s_axil_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Index and data registers; bytes land when the write completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      index_q <= CRT_INDEX_RST;
      start_q <= CRT_START_RST;
      curs_q <= CRT_CURS_RST;
    end else if (do_write && w_lane_q) begin
      if (aw_addr_q == CRT_OFF_INDEX) begin
        index_q <= w_byte_q[4:0];
      end else if (aw_addr_q == CRT_OFF_DATA) begin
        unique case (index_q)
          CRT_IDX_START_HI: start_q[13:8] <= w_byte_q[5:0];
          CRT_IDX_START_LO: start_q[7:0] <= w_byte_q;
          CRT_IDX_CURS_HI: curs_q[13:8] <= w_byte_q[5:0];
          CRT_IDX_CURS_LO: curs_q[7:0] <= w_byte_q;
          // Format registers are fixed; writes there are dropped
          default: index_q <= index_q;
        endcase
      end
    end
  end

  assign cfg.start_addr = start_q;
  assign cfg.cursor_addr = curs_q;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axil_arready = !rvalid_q;

  // One read at a time, answered the cycle after the address
  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= CRT_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= CRT_RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (s_axil_araddr == CRT_OFF_INDEX) begin
        rdata_q[4:0] <= index_q;
      end else if (s_axil_araddr == CRT_OFF_DATA) begin
        if (index_q == CRT_IDX_START_HI) rdata_q[5:0] <= start_q[13:8];
        else if (index_q == CRT_IDX_START_LO) rdata_q[7:0] <= start_q[7:0];
        else if (index_q == CRT_IDX_CURS_HI) rdata_q[5:0] <= curs_q[13:8];
        else if (index_q == CRT_IDX_CURS_LO) rdata_q[7:0] <= curs_q[7:0];
      end else if (s_axil_araddr == CRT_OFF_STAT) begin
        // Live raster state snapshot
        rdata_q <= {7'h00, cfg.st_run, cfg.st_field, cfg.st_de, cfg.st_vsync,
          cfg.st_hsync, 1'b0, cfg.st_row, cfg.st_addr};
      end else begin
        rresp_q <= CRT_RESP_SLVERR;
      end
    end else if (s_axil_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axil_bvalid = bvalid_q;
  assign s_axil_bresp = bresp_q;
  assign s_axil_rvalid = rvalid_q;
  assign s_axil_rdata = rdata_q;
  assign s_axil_rresp = rresp_q;

  // Both halves held produce a response next cycle
  a_write_resp: assert property (@(posedge mclk) disable iff (rst)
    do_write |=> bvalid_q && !aw_have_q && !w_have_q)
    else $error("write not answered");

endmodule : crt_axil_regs

// [test/crt_video_model.sv]
`timescale 1ns/10ps
// Far-side dot logic: strobes the pixel latch and measures the sync timing
module crt_video_model (
  // Character clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Video timing from the controller
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic display_active,
  // Measured timing and shift control
  output logic [8:0] line_len,
  output logic [8:0] vs_phase,
  output logic char_load
);
  logic hs_q; // Last horizontal sync level
  logic vs_q; // Last vertical sync level
  logic [8:0] cnt_q; // Characters since horizontal sync began

  // ----------------------------------------
  // Shift register control
  // ----------------------------------------
  // One latch strobe per displayed character; blanked cells load nothing
  always_ff @(posedge mclk) begin
    char_load <= display_active;
  end

  // ----------------------------------------
  // Sync measurement
  // ----------------------------------------
  // Line length is counted edge to edge, so a wrong total shows at once
  always_ff @(posedge mclk) begin
    hs_q <= hsync_out;
    vs_q <= vsync_out;
    if (rst) begin
      cnt_q <= 9'h000;
      line_len <= 9'h000;
      vs_phase <= 9'h000;
    end else if (hsync_out && !hs_q) begin
      // New line: keep the length of the one just ended
      line_len <= cnt_q;
      cnt_q <= 9'h001;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
    // Position in the line where vertical sync starts, tells the fields apart
    if (!rst && vsync_out && !vs_q) begin
      vs_phase <= cnt_q;
    end
  end
endmodule : crt_video_model

// [test/crt_raster_timing_tb.sv]
`timescale 1ns/10ps
module crt_raster_timing_tb import crt_pkg::*; ;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic mclk, rst, display_reset_n, format_select;
  logic [7:0] s_axil_awaddr, s_axil_araddr;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic s_axil_rvalid, s_axil_rready;
  logic [13:0] refresh_addr, ra_p, start_v, cur_v;
  logic [4:0] char_row_addr;
  logic [18:0] graphics_addr;
  logic hsync_out, vsync_out, display_active, cursor_out, hs_p, de_p;
  logic [8:0] line_len, vs_phase, ph0;
  logic [31:0] rd_v;
  logic chk_on, cur_on; // Gates for the free-running video checks
  int n_mismatch, n_compared, n_hit, seed_v;

`define chk(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  n_mismatch++; end end

  crt_raster_timing crt_raster_timing_inst (.mclk(mclk), .rst(rst),
    .display_reset_n(display_reset_n), .format_select(format_select),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready), .refresh_addr(refresh_addr),
    .char_row_addr(char_row_addr), .graphics_addr(graphics_addr),
    .hsync_out(hsync_out), .vsync_out(vsync_out),
    .display_active(display_active), .cursor_out(cursor_out));

  crt_video_model crt_video_model_inst (.mclk(mclk), .rst(rst),
    .hsync_out(hsync_out), .vsync_out(vsync_out), .display_active(display_active),
    .line_len(line_len), .vs_phase(vs_phase), .char_load());

  // Character clock at 250 MHz
  always #2 mclk = ~mclk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Each valid is held up to the edge that takes it; answers are read at their edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] b_r;
    logic done;
    int n, dly;
    done = 1'b0;
    dly = $urandom_range(2);
    @(posedge mclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
      if (s_axil_bready && s_axil_bvalid === 1'b1) begin
        done = 1'b1;
        b_r = s_axil_bresp;
        s_axil_bready <= 1'b0;
      end else if (n == dly) begin
        // Slow or prompt response acceptance
        s_axil_bready <= 1'b1;
      end
    end
    `chk(b_r, er)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic [1:0] r_r;
    logic done;
    int n;
    done = 1'b0;
    @(posedge mclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid === 1'b1) begin
        done = 1'b1;
        d = s_axil_rdata;
        r_r = s_axil_rresp;
        s_axil_rready <= 1'b0;
      end
    end
    `chk(r_r, er)
  endtask : axi_rd

  // Index first, then the data register that it selects
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] v);
    axi_wr(CRT_OFF_INDEX, {27'h0000000, idx}, CRT_RESP_OKAY);
    axi_wr(CRT_OFF_DATA, {24'h000000, v}, CRT_RESP_OKAY);
  endtask : reg_wr

  task automatic wait_rise(input int sel);
    logic p, c;
    int n;
    p = 1'b1;
    for (n = 0; n < 40000; n++) begin
      @(negedge mclk);
      c = sel ? display_active : vsync_out;
      if (c === 1'b1 && p === 1'b0) break;
      p = c;
    end
    // An edge that never comes is a failure
    if (n == 40000) n_mismatch++;
  endtask : wait_rise

  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Free-running video checks
  // ----------------------------------------
  // Addresses step by one per character, also through retrace
  always @(negedge mclk) begin
    if (!rst && chk_on) begin
      `chk(graphics_addr, {char_row_addr, refresh_addr})
      if (hsync_out && hs_p) `chk(refresh_addr, ra_p + 14'h0001)
      if (display_active && de_p) `chk(refresh_addr, ra_p + 14'h0001)
      if (cursor_out && cur_on) `chk(refresh_addr, cur_v)
      if (cursor_out && cur_on) n_hit++;
    end
    hs_p = hsync_out;
    de_p = display_active;
    ra_p = refresh_addr;
  end

  // Watchdog above the two frames and two fields the run takes
  initial begin
    repeat (98000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {mclk, rst, display_reset_n, format_select, chk_on, cur_on} = 6'h3A;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 48'h000000000000;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 5'h00;
    s_axil_wstrb = 4'h1;
    {n_mismatch, n_compared, n_hit} = 0;
    seed_v = $urandom(32'h21E0);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `chk({refresh_addr, hsync_out, vsync_out, display_active}, 17'h00000)
    start_v = 14'($urandom_range(16383));
    cur_v = start_v + 14'($urandom_range(1999));
    reg_wr(CRT_IDX_START_HI, {2'h0, start_v[13:8]});
    reg_wr(CRT_IDX_START_LO, start_v[7:0]);
    reg_wr(CRT_IDX_CURS_HI, {2'h0, cur_v[13:8]});
    reg_wr(CRT_IDX_CURS_LO, cur_v[7:0]);
    // Unmapped place and a dropped index
    axi_wr(8'h10, 32'h00000055, CRT_RESP_SLVERR);
    axi_rd(8'h10, CRT_RESP_SLVERR, rd_v);
    `chk(rd_v, 32'h00000000)
    reg_wr(5'h05, 8'hA5);
    axi_rd(CRT_OFF_DATA, CRT_RESP_OKAY, rd_v);
    `chk(rd_v, 32'h00000000)
    // Display reset shows the start address with everything else low
    @(posedge mclk);
    display_reset_n <= 1'b0;
    repeat (6) @(negedge mclk);
    `chk({refresh_addr, char_row_addr}, {start_v, 5'h00})
    `chk({hsync_out, vsync_out, display_active, cursor_out}, 4'h0)
    {chk_on, cur_on} = 2'h3;
    @(posedge mclk);
    display_reset_n <= 1'b1;
    wait_rise(1);
    `chk({refresh_addr, char_row_addr}, {start_v, 5'h00})
    axi_rd(CRT_OFF_STAT, CRT_RESP_OKAY, rd_v);
    `chk({rd_v[24], rd_v[19]}, 2'h2)
    // Scroll: the next frame starts at the new base
    start_v = 14'($urandom_range(16383));
    reg_wr(CRT_IDX_START_HI, {2'h0, start_v[13:8]});
    reg_wr(CRT_IDX_START_LO, start_v[7:0]);
    wait_rise(0);
    @(negedge mclk);
    ph0 = vs_phase;
    wait_rise(1);
    `chk(refresh_addr, start_v)
    wait_rise(0);
    @(negedge mclk);
    `chk(vs_phase, ph0)
    `chk(line_len, 9'(CRT_FMT0.h_total) + 9'h001)
    `chk(n_hit != 0, 1'b1)
    // Second set: other line length and interlaced fields
    @(posedge mclk);
    format_select <= 1'b1;
    repeat (300) @(negedge mclk);
    `chk(line_len, 9'(CRT_FMT1.h_total) + 9'h001)
    wait_rise(0);
    @(negedge mclk);
    ph0 = vs_phase;
    wait_rise(0);
    @(negedge mclk);
    `chk(vs_phase != ph0, 1'b1)
    end_of_test();
  end
endmodule : crt_raster_timing_tb
